/* File: src/icc_consts.vh */
// Constants for the interrupt combine and status pin control block.
// Operation
// - Combine-select 1: combined interrupt only while all unmasked flags are active.
// - Combine-select 0 (reset): combined interrupt while any unmasked flag is active.
// - Interrupt circuit works only while control bit 0 is 1; resets to 0.
// - Enable 0: no interrupt on status pins, flag bits stay unchanged.
// - Live-state register always returns present level of every source except unlock, which reads 0 while input loss is active.
// - Slew status bits 7..4: sec rise, sec fall, pri rise, pri fall; 3..0 reserved.
// - Open-drain bit 1 for pin b, bit 0 for pin a: drive low only.
// - Transient-limit bit 5 pin b, bit 4 pin a selects reduced-transient driver.
// - Flag set on source edge: polarity 1 rising, polarity 0 falling.
// - A set flag stays set until software writes 0 to it.
// - Mask bit 1 removes that source from the combined interrupt.
// - Input loss that unlocks the PLL reports input loss only, not unlock.
`ifndef ICC_CONSTS_VH
`define ICC_CONSTS_VH

// ----------------------------------------------------------------------------
// Register indices; byte address is four times the index.
// ----------------------------------------------------------------------------
`define ICC_IDX_LIVE 8'h0d
`define ICC_IDX_MASK 8'h0e
`define ICC_IDX_POL 8'h0f
`define ICC_IDX_FLAG 8'h10
`define ICC_IDX_CTRL 8'h11
`define ICC_IDX_SLEW 8'h12
`define ICC_IDX_STATUS_PIN_DRIVER_CONTROL 8'h13
`define ICC_IDX_IRQ_STAT 8'h14
`define ICC_IDX_IRQ_MASK 8'h15
`define ICC_IDX_ROUTE 8'h16

// ----------------------------------------------------------------------------
// Field positions.
// ----------------------------------------------------------------------------
`define ICC_CTRL_EN 0
`define ICC_CTRL_AND 1
`define ICC_STAT_OD_A 0
`define ICC_STAT_OD_B 1
`define ICC_STAT_TL_A 4
`define ICC_STAT_TL_B 5
`define ICC_ROUTE_A 0
`define ICC_ROUTE_B 1

// ----------------------------------------------------------------------------
// Reset values and bus answers.
// ----------------------------------------------------------------------------
`define ICC_CTRL_RST 2'h0
`define ICC_SRC_RST 4'h0
`define ICC_STATUS_PIN_DRIVER_CONTROL_RST 6'h00
`define ICC_ROUTE_RST 2'h1
`define ICC_RESP_OKAY 2'h0
`define ICC_RESP_SLVERR 2'h2

`endif

/* File: src/icc_edge_sync.v */
// Two-stage synchroniser with edge detection for the interrupt sources.
`timescale 1ns/100ps
module icc_edge_sync #(
  parameter W = 4
) (
  // Clock and reset.
  input wire clk_i,
  input wire rst_n_i,
  // Asynchronous levels in.
  input wire [W-1:0] async_i,
  // Synchronised level and one-cycle edge pulses.
  output wire [W-1:0] level_o,
  output wire [W-1:0] rise_o,
  output wire [W-1:0] fall_o
);

  reg [W-1:0] meta_r;
  reg [W-1:0] sync_r;
  reg [W-1:0] prev_r;

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_r <= {W{1'b0}};
      sync_r <= {W{1'b0}};
      prev_r <= {W{1'b0}};
    end else begin
      meta_r <= async_i;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign level_o = sync_r;
  assign rise_o = sync_r & ~prev_r;
  assign fall_o = ~sync_r & prev_r;

endmodule // icc_edge_sync

/* File: src/icc_top.v */
// Interrupt combining, status pin control and AXI4-Lite register slave.
//
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/100ps
`include "icc_consts.vh"
module icc_top (
  // Clock and reset.
  input wire clk_i,
  input wire rst_n_i,
  // AXI4-Lite write address channel.
  input wire [31:0] s_axi_awaddr_i,
  input wire s_axi_awvalid_i,
  output reg s_axi_awready_o,
  // AXI4-Lite write data channel.
  input wire [31:0] s_axi_wdata_i,
  input wire [3:0] s_axi_wstrb_i,
  input wire s_axi_wvalid_i,
  output reg s_axi_wready_o,
  // AXI4-Lite write response channel.
  output reg [1:0] s_axi_bresp_o,
  output reg s_axi_bvalid_o,
  input wire s_axi_bready_i,
  // AXI4-Lite read address channel.
  input wire [31:0] s_axi_araddr_i,
  input wire s_axi_arvalid_i,
  output reg s_axi_arready_o,
  // AXI4-Lite read data channel.
  output reg [31:0] s_axi_rdata_o,
  output reg [1:0] s_axi_rresp_o,
  output reg s_axi_rvalid_o,
  input wire s_axi_rready_i,
  // Internal interrupt sources.
  input wire pll_unlocked_i,
  input wire input_lost_i,
  input wire vco_cal_i,
  input wire reference_switch_back_i,
  // Slew-rate detector indicators.
  input wire secondary_rise_valid_i,
  input wire secondary_fall_valid_i,
  input wire primary_rise_valid_i,
  input wire primary_fall_valid_i,
  // Status pins; enables are active low.
  output reg indicator_pin_a_o,
  output reg indicator_pin_a_oe_n_o,
  output reg pin_a_transient_limit_o,
  output reg indicator_pin_b_o,
  output reg indicator_pin_b_oe_n_o,
  output reg pin_b_transient_limit_o,
  // System interrupt.
  output reg irq_o
);

  // --------------------------------------------------------------------------
  // Helper functions.
  // --------------------------------------------------------------------------
  // Source vectors are {unlock, input loss, calibration, switch back}.
  function [7:0] src_pack;
    input [3:0] v;
    begin
      src_pack = {v[3], v[2], v[1], 3'h0, v[0], 1'b0};
    end
  endfunction

  function [3:0] src_unpack;
    input [7:0] b;
    begin
      src_unpack = {b[7], b[6], b[5], b[1]};
    end
  endfunction

  function [7:0] reg_index;
    input [31:0] addr;
    begin
      reg_index = addr[9:2];
    end
  endfunction

  function addr_mapped;
    input [31:0] addr;
    reg [7:0] i;
    begin
      i = addr[9:2];
      addr_mapped = (addr[31:10] == 22'h0) && (i >= `ICC_IDX_LIVE) && (i <= `ICC_IDX_ROUTE);
    end
  endfunction

  // --------------------------------------------------------------------------
  // Source synchronisation.
  // --------------------------------------------------------------------------
  wire [3:0] src_level;
  wire [3:0] src_rise;
  wire [3:0] src_fall;
  wire [3:0] slew_level;
  wire [3:0] raw_src;

  assign raw_src = {pll_unlocked_i, input_lost_i, vco_cal_i, reference_switch_back_i};

  icc_edge_sync #(
    .W(4)
  ) u_src_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .async_i(raw_src),
    .level_o(src_level),
    .rise_o(src_rise),
    .fall_o(src_fall)
  );

  icc_edge_sync #(
    .W(4)
  ) u_slew_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .async_i({secondary_rise_valid_i, secondary_fall_valid_i, primary_rise_valid_i, primary_fall_valid_i}),
    .level_o(slew_level),
    .rise_o(),
    .fall_o()
  );

  // --------------------------------------------------------------------------
  // Registers.
  // --------------------------------------------------------------------------
  reg [1:0] ctrl_r;
  reg [3:0] mask_r;
  reg [3:0] pol_r;
  reg [3:0] flag_r;
  reg [3:0] flag_nxt;
  reg [5:0] status_pin_driver_control_r;
  reg [3:0] irq_stat_r;
  reg [3:0] irq_stat_nxt;
  reg [3:0] irq_mask_r;
  reg [1:0] route_r;
  reg unlock_prev_r;
  reg combined_r;
  reg combined_nxt;

  // Input loss takes precedence, so an unlock it causes is hidden.
  wire [3:0] live_src = {src_level[3] & ~src_level[2], src_level[2:0]};
  wire unlock_prev = unlock_prev_r;
  wire unlock_rise = live_src[3] & ~unlock_prev;
  wire unlock_fall = ~live_src[3] & unlock_prev;
  wire [3:0] rise_all = {unlock_rise, src_rise[2:0]};
  wire [3:0] fall_all = {unlock_fall, src_fall[2:0]};
  // Polarity 1 picks the rising edge, 0 the falling edge.
  wire [3:0] src_edge = (pol_r & rise_all) | (~pol_r & fall_all);
  wire irq_en = ctrl_r[`ICC_CTRL_EN];

  // --------------------------------------------------------------------------
  // AXI4-Lite write path.
  // --------------------------------------------------------------------------
  reg aw_have_r;
  reg w_have_r;
  reg [31:0] aw_addr_r;
  reg [31:0] w_data_r;
  reg w_lane0_r;

  wire aw_take = s_axi_awvalid_i & s_axi_awready_o;
  wire w_take = s_axi_wvalid_i & s_axi_wready_o;
  wire wr_do = aw_have_r & w_have_r & ~s_axi_bvalid_o;
  wire wr_ok = wr_do & addr_mapped(aw_addr_r) & w_lane0_r;
  wire [7:0] wr_idx = reg_index(aw_addr_r);
  wire [7:0] wr_byte = w_data_r[7:0];

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      aw_addr_r <= 32'h0;
      w_data_r <= 32'h0;
      w_lane0_r <= 1'b0;
      s_axi_awready_o <= 1'b0;
      s_axi_wready_o <= 1'b0;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= `ICC_RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_have_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr_i;
      end else if (wr_do) begin
        aw_have_r <= 1'b0;
      end
      if (w_take) begin
        w_have_r <= 1'b1;
        w_data_r <= s_axi_wdata_i;
        w_lane0_r <= s_axi_wstrb_i[0];
      end else if (wr_do) begin
        w_have_r <= 1'b0;
      end
      // Ready only while the holding slot is empty and no answer is pending.
      s_axi_awready_o <= ~aw_have_r & ~aw_take & ~s_axi_bvalid_o & ~wr_do;
      s_axi_wready_o <= ~w_have_r & ~w_take & ~s_axi_bvalid_o & ~wr_do;
      if (wr_do) begin
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o <= addr_mapped(aw_addr_r) ? `ICC_RESP_OKAY : `ICC_RESP_SLVERR;
      end else if (s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Flag and interrupt status next state.
  // --------------------------------------------------------------------------
  always @* begin
    flag_nxt = flag_r;
    if (irq_en) begin
      // Writing 0 clears, writing 1 keeps; a new edge wins over the clear.
      if (wr_ok && wr_idx == `ICC_IDX_FLAG) begin
        flag_nxt = flag_r & src_unpack(wr_byte);
      end
      flag_nxt = flag_nxt | src_edge;
    end
    // Disabled circuit holds every flag bit.
  end

  always @* begin
    irq_stat_nxt = irq_stat_r;
    if (wr_ok && wr_idx == `ICC_IDX_IRQ_STAT) begin
      irq_stat_nxt = irq_stat_r & ~src_unpack(wr_byte);
    end
    irq_stat_nxt = irq_stat_nxt | (flag_nxt & ~flag_r);
  end

  // --------------------------------------------------------------------------
  // Combining logic.
  // --------------------------------------------------------------------------
  always @* begin
    combined_nxt = 1'b0;
    if (!irq_en) begin
      combined_nxt = 1'b0;
    end else if (ctrl_r[`ICC_CTRL_AND]) begin
      // Every unmasked flag must be set; nothing unmasked means no interrupt.
      combined_nxt = (&(flag_r | mask_r)) & (|(~mask_r));
    end else begin
      combined_nxt = |(flag_r & ~mask_r);
    end
  end

  // --------------------------------------------------------------------------
  // Register storage.
  // --------------------------------------------------------------------------
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_r <= `ICC_CTRL_RST;
      mask_r <= `ICC_SRC_RST;
      pol_r <= `ICC_SRC_RST;
      flag_r <= `ICC_SRC_RST;
      status_pin_driver_control_r <= `ICC_STATUS_PIN_DRIVER_CONTROL_RST;
      irq_stat_r <= `ICC_SRC_RST;
      irq_mask_r <= `ICC_SRC_RST;
      route_r <= `ICC_ROUTE_RST;
      unlock_prev_r <= 1'b0;
      combined_r <= 1'b0;
    end else begin
      flag_r <= flag_nxt;
      irq_stat_r <= irq_stat_nxt;
      unlock_prev_r <= live_src[3];
      combined_r <= combined_nxt;
      if (wr_ok) begin
        if (wr_idx == `ICC_IDX_MASK) begin
          mask_r <= src_unpack(wr_byte);
        end else if (wr_idx == `ICC_IDX_POL) begin
          pol_r <= src_unpack(wr_byte);
        end else if (wr_idx == `ICC_IDX_CTRL) begin
          ctrl_r <= wr_byte[1:0];
        end else if (wr_idx == `ICC_IDX_STATUS_PIN_DRIVER_CONTROL) begin
          status_pin_driver_control_r <= wr_byte[5:0];
        end else if (wr_idx == `ICC_IDX_IRQ_MASK) begin
          irq_mask_r <= src_unpack(wr_byte);
        end else if (wr_idx == `ICC_IDX_ROUTE) begin
          route_r <= wr_byte[1:0];
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // AXI4-Lite read path.
  // --------------------------------------------------------------------------
  reg [7:0] rd_byte;
  wire [7:0] rd_idx = reg_index(s_axi_araddr_i);

  always @* begin
    rd_byte = 8'h00;
    if (rd_idx == `ICC_IDX_LIVE) begin
      rd_byte = src_pack(live_src);
    end else if (rd_idx == `ICC_IDX_MASK) begin
      rd_byte = src_pack(mask_r);
    end else if (rd_idx == `ICC_IDX_POL) begin
      rd_byte = src_pack(pol_r);
    end else if (rd_idx == `ICC_IDX_FLAG) begin
      rd_byte = src_pack(flag_r);
    end else if (rd_idx == `ICC_IDX_CTRL) begin
      rd_byte = {6'h00, ctrl_r};
    end else if (rd_idx == `ICC_IDX_SLEW) begin
      rd_byte = {slew_level, 4'h0};
    end else if (rd_idx == `ICC_IDX_STATUS_PIN_DRIVER_CONTROL) begin
      rd_byte = {2'h0, status_pin_driver_control_r};
    end else if (rd_idx == `ICC_IDX_IRQ_STAT) begin
      rd_byte = src_pack(irq_stat_r);
    end else if (rd_idx == `ICC_IDX_IRQ_MASK) begin
      rd_byte = src_pack(irq_mask_r);
    end else if (rd_idx == `ICC_IDX_ROUTE) begin
      rd_byte = {6'h00, route_r};
    end
  end

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h0;
      s_axi_rresp_o <= `ICC_RESP_OKAY;
    end else begin
      s_axi_arready_o <= ~s_axi_rvalid_o & ~(s_axi_arvalid_i & s_axi_arready_o);
      if (s_axi_arvalid_i && s_axi_arready_o) begin
        s_axi_rvalid_o <= 1'b1;
        if (addr_mapped(s_axi_araddr_i)) begin
          s_axi_rdata_o <= {24'h0, rd_byte};
          s_axi_rresp_o <= `ICC_RESP_OKAY;
        end else begin
          s_axi_rdata_o <= 32'h0;
          s_axi_rresp_o <= `ICC_RESP_SLVERR;
        end
      end else if (s_axi_rready_i) begin
        s_axi_rvalid_o <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Status pins and system interrupt.
  // --------------------------------------------------------------------------
  // The combined level is registered, so pins lag it by one more clock.
  wire lvl_a = combined_r & route_r[`ICC_ROUTE_A];
  wire lvl_b = combined_r & route_r[`ICC_ROUTE_B];

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      indicator_pin_a_o <= 1'b0;
      indicator_pin_a_oe_n_o <= 1'b0;
      pin_a_transient_limit_o <= 1'b0;
      indicator_pin_b_o <= 1'b0;
      indicator_pin_b_oe_n_o <= 1'b0;
      pin_b_transient_limit_o <= 1'b0;
      irq_o <= 1'b0;
    end else begin
      // Open drain drives low and floats for a high level.
      if (status_pin_driver_control_r[`ICC_STAT_OD_A]) begin
        indicator_pin_a_o <= 1'b0;
        indicator_pin_a_oe_n_o <= lvl_a;
      end else begin
        indicator_pin_a_o <= lvl_a;
        indicator_pin_a_oe_n_o <= 1'b0;
      end
      if (status_pin_driver_control_r[`ICC_STAT_OD_B]) begin
        indicator_pin_b_o <= 1'b0;
        indicator_pin_b_oe_n_o <= lvl_b;
      end else begin
        indicator_pin_b_o <= lvl_b;
        indicator_pin_b_oe_n_o <= 1'b0;
      end
      pin_a_transient_limit_o <= status_pin_driver_control_r[`ICC_STAT_TL_A];
      pin_b_transient_limit_o <= status_pin_driver_control_r[`ICC_STAT_TL_B];
      irq_o <= |(irq_stat_nxt & irq_mask_r);
    end
  end

endmodule // icc_top

/* File: testbench/icc_props.sv */
// Port checker for the interrupt combine and status pin block.
`timescale 1ns/100ps
`include "icc_consts.vh"
module icc_props (
  // Clock and reset.
  input wire clk_i,
  input wire rst_n_i,
  // Register bus.
  input wire [31:0] s_axi_awaddr_i,
  input wire s_axi_awvalid_i,
  input wire s_axi_awready_o,
  input wire [31:0] s_axi_wdata_i,
  input wire [3:0] s_axi_wstrb_i,
  input wire s_axi_wvalid_i,
  input wire s_axi_wready_o,
  input wire [1:0] s_axi_bresp_o,
  input wire s_axi_bvalid_o,
  input wire s_axi_bready_i,
  input wire [31:0] s_axi_araddr_i,
  input wire s_axi_arvalid_i,
  input wire s_axi_arready_o,
  input wire [31:0] s_axi_rdata_o,
  input wire [1:0] s_axi_rresp_o,
  input wire s_axi_rvalid_o,
  input wire s_axi_rready_i,
  // Status pins and interrupt.
  input wire indicator_pin_a_o,
  input wire indicator_pin_a_oe_n_o,
  input wire pin_a_transient_limit_o,
  input wire indicator_pin_b_o,
  input wire indicator_pin_b_oe_n_o,
  input wire pin_b_transient_limit_o,
  input wire irq_o
);
  localparam [31:0] A_CTRL = {22'h0, `ICC_IDX_CTRL, 2'b00};
  localparam [31:0] A_STAT = {22'h0, `ICC_IDX_STATUS_PIN_DRIVER_CONTROL, 2'b00};
  localparam [31:0] A_SLEW = {22'h0, `ICC_IDX_SLEW, 2'b00};
  reg [31:0] aw_r, ar_r;
  reg [7:0] wd_r;
  reg st_r, bv_r, en_r;
  wire wr_fire = s_axi_bvalid_o && !bv_r && s_axi_bresp_o == `ICC_RESP_OKAY && st_r;

  // --------------------------------------------------------------------------
  // Shadow of the enable bit, rebuilt from completed writes.
  // --------------------------------------------------------------------------
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      aw_r <= 32'h0;
      ar_r <= 32'h0;
      wd_r <= 8'h00;
      st_r <= 1'b0;
      bv_r <= 1'b0;
      en_r <= 1'b0;
    end else begin
      bv_r <= s_axi_bvalid_o;
      if (s_axi_awvalid_i && s_axi_awready_o) aw_r <= s_axi_awaddr_i;
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        wd_r <= s_axi_wdata_i[7:0];
        st_r <= s_axi_wstrb_i[0];
      end
      if (s_axi_arvalid_i && s_axi_arready_o) ar_r <= s_axi_araddr_i;
      if (wr_fire && aw_r == A_CTRL) en_r <= wd_r[0];
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  od_exclusive_a:
  assert property (!(indicator_pin_a_o && indicator_pin_a_oe_n_o) && !(indicator_pin_b_o && indicator_pin_b_oe_n_o))
    else $error("status pin driven high while released");
  pins_quiet_a:
  assert property ((!en_r) [*3] |-> !indicator_pin_a_o && !indicator_pin_a_oe_n_o && !indicator_pin_b_o
    && !indicator_pin_b_oe_n_o) else $error("status pin active while disabled");
  limit_follow_a:
  assert property (wr_fire && aw_r == A_STAT |-> ##[0:2] (pin_a_transient_limit_o == wd_r[4]
    && pin_b_transient_limit_o == wd_r[5])) else $error("transient limit select wrong");
  slew_reserved_a:
  assert property (s_axi_rvalid_o && ar_r == A_SLEW |-> s_axi_rdata_o[3:0] == 4'h0 && s_axi_rdata_o[31:8] == 24'h0)
    else $error("reserved slew bits not zero");
  irq_clear_a:
  assert property ($fell(irq_o) |-> s_axi_bvalid_o || $past(s_axi_bvalid_o)) else $error("irq dropped without write");
  bresp_hold_a:
  assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
    else $error("write response not held");
  rdata_hold_a:
  assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o)
    && $stable(s_axi_rresp_o)) else $error("read data not held");
  wr_refuse_a:
  assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o) else $error("write taken while busy");
  rd_refuse_a:
  assert property (s_axi_rvalid_o |-> !s_axi_arready_o) else $error("read taken while busy");
  unmapped_rd_a:
  assert property (s_axi_rvalid_o && (ar_r[31:2] < 30'h0d || ar_r[31:2] > 30'h16) |->
    s_axi_rresp_o == `ICC_RESP_SLVERR && s_axi_rdata_o == 32'h0) else $error("unmapped read answered");
  cover property (wr_fire && aw_r == A_CTRL);
  cover property ($rose(irq_o));
  cover property (indicator_pin_a_oe_n_o);
endmodule // icc_props

bind icc_top icc_props u_props (.*);

/* File: testbench/icc_pin_host.sv */
// Host-side model of the two status pin wires with pull-ups.
`timescale 1ns/100ps
module icc_pin_host (
  // Pin drivers from the block.
  input wire indicator_pin_a_o,
  input wire indicator_pin_a_oe_n_o,
  input wire indicator_pin_b_o,
  input wire indicator_pin_b_oe_n_o,
  // Levels seen by the host.
  output wire pin_a_level_o,
  output wire pin_b_level_o
);
  // A released pin floats up to the pull-up, never to the last driven value.
  assign pin_a_level_o = indicator_pin_a_oe_n_o ? 1'b1 : indicator_pin_a_o;
  assign pin_b_level_o = indicator_pin_b_oe_n_o ? 1'b1 : indicator_pin_b_o;
endmodule // icc_pin_host

/* File: testbench/tb_interrupt_combine_control.sv */
// Self-checking bench for the interrupt combine and status pin block.
`timescale 1ns/100ps
`include "icc_consts.vh"
module tb_interrupt_combine_control;
  localparam bit [1:0] OK = `ICC_RESP_OKAY;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [31:0] s_axi_awaddr_i = 32'h0, s_axi_wdata_i = 32'h0, s_axi_araddr_i = 32'h0;
  logic [3:0] s_axi_wstrb_i = 4'hf;
  logic s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0;
  logic s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0;
  logic pll_unlocked_i = 1'b0, input_lost_i = 1'b0, vco_cal_i = 1'b0, reference_switch_back_i = 1'b0;
  logic secondary_rise_valid_i = 1'b0, secondary_fall_valid_i = 1'b0;
  logic primary_rise_valid_i = 1'b0, primary_fall_valid_i = 1'b0;
  logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o, irq_o;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
  logic [31:0] s_axi_rdata_o;
  logic indicator_pin_a_o, indicator_pin_a_oe_n_o, pin_a_transient_limit_o;
  logic indicator_pin_b_o, indicator_pin_b_oe_n_o, pin_b_transient_limit_o;
  logic pin_a_level_o, pin_b_level_o;
  int err_count = 0;
  int samples_checked = 0;
  logic [31:0] seed = 32'h44;
  logic [31:0] rv;

  icc_top u_dut (.*);
  icc_pin_host u_host (.*);

  always #20 clk_i = ~clk_i;

  // --------------------------------------------------------------------------
  // Helpers.
  // --------------------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Source vector is {unlock, input lost, calibration, switch back}.
  function automatic logic [7:0] lay(input logic [3:0] s);
    return {s[3], s[2], s[1], 3'h0, s[0], 1'b0};
  endfunction

  task automatic stop_test();
    if (err_count == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Ready and valid are looked at mid-cycle, so the handshake edge is the next rising one.
  task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
    logic a, w, b;
    logic [1:0] r;
    @(posedge clk_i);
    s_axi_awaddr_i <= {22'h0, idx, 2'b00};
    s_axi_wdata_i <= {24'h0, d};
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    s_axi_bready_i <= 1'b1;
    repeat (40) begin
      @(negedge clk_i);
      a = s_axi_awready_o && s_axi_awvalid_i;
      w = s_axi_wready_o && s_axi_wvalid_i;
      b = s_axi_bvalid_o;
      r = s_axi_bresp_o;
      @(posedge clk_i);
      if (a) s_axi_awvalid_i <= 1'b0;
      if (w) s_axi_wvalid_i <= 1'b0;
      if (b) begin
        s_axi_bready_i <= 1'b0;
        chk(r, er);
        return;
      end
    end
    err_count++;
    stop_test();
  endtask

  task automatic rd(input logic [7:0] idx, input logic [7:0] ev, input logic [1:0] er);
    logic a, v;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge clk_i);
    s_axi_araddr_i <= {22'h0, idx, 2'b00};
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i <= 1'b1;
    repeat (40) begin
      @(negedge clk_i);
      a = s_axi_arready_o && s_axi_arvalid_i;
      v = s_axi_rvalid_o;
      d = s_axi_rdata_o;
      r = s_axi_rresp_o;
      @(posedge clk_i);
      if (a) s_axi_arvalid_i <= 1'b0;
      if (v) begin
        s_axi_rready_i <= 1'b0;
        chk(d, {24'h0, ev});
        chk(r, er);
        return;
      end
    end
    err_count++;
    stop_test();
  endtask

  // Sources pass two sync stages, the flag, the combine and the pin register.
  task automatic src(input logic [3:0] s);
    @(posedge clk_i);
    {pll_unlocked_i, input_lost_i, vco_cal_i, reference_switch_back_i} <= s;
    repeat (6) @(posedge clk_i);
  endtask

  task automatic pin(input logic ea, input logic eb);
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    chk(pin_a_level_o, ea);
    chk(pin_b_level_o, eb);
  endtask

  // --------------------------------------------------------------------------
  // Main sequence.
  // --------------------------------------------------------------------------
  initial begin
    repeat (3) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rd(`ICC_IDX_CTRL, 8'h00, OK);
    rd(`ICC_IDX_STATUS_PIN_DRIVER_CONTROL, 8'h00, OK);
    rd(`ICC_IDX_ROUTE, 8'h01, OK);
    rd(8'h17, 8'h00, `ICC_RESP_SLVERR);
    wr(8'h17, 8'hff, `ICC_RESP_SLVERR);
    for (int i = 0; i < 4; i++) begin
      rv = xs();
      {secondary_rise_valid_i, secondary_fall_valid_i, primary_rise_valid_i, primary_fall_valid_i} <= rv[3:0];
      repeat (4) @(posedge clk_i);
      rd(`ICC_IDX_SLEW, {rv[3:0], 4'h0}, OK);
      wr(`ICC_IDX_MASK, rv[15:8], OK);
      rd(`ICC_IDX_MASK, rv[15:8] & 8'he2, OK);
    end
    wr(`ICC_IDX_POL, 8'he2, OK);
    wr(`ICC_IDX_MASK, 8'h00, OK);
    for (int i = 0; i < 6; i++) begin
      rv = xs();
      src(rv[3:0]);
      rd(`ICC_IDX_LIVE, lay({rv[3] & ~rv[2], rv[2:0]}), OK);
    end
    rd(`ICC_IDX_FLAG, 8'h00, OK);
    pin(1'b0, 1'b0);
    src(4'h0);
    wr(`ICC_IDX_CTRL, 8'h01, OK);
    src(4'h8);
    rd(`ICC_IDX_FLAG, 8'h80, OK);
    pin(1'b1, 1'b0);
    wr(`ICC_IDX_FLAG, 8'hff, OK);
    rd(`ICC_IDX_FLAG, 8'h80, OK);
    wr(`ICC_IDX_CTRL, 8'h03, OK);
    pin(1'b0, 1'b0);
    wr(`ICC_IDX_MASK, 8'h62, OK);
    pin(1'b1, 1'b0);
    wr(`ICC_IDX_ROUTE, 8'h02, OK);
    pin(1'b0, 1'b1);
    wr(`ICC_IDX_FLAG, 8'h00, OK);
    rd(`ICC_IDX_FLAG, 8'h00, OK);
    pin(1'b0, 1'b0);
    wr(`ICC_IDX_MASK, 8'h00, OK);
    wr(`ICC_IDX_CTRL, 8'h01, OK);
    wr(`ICC_IDX_POL, 8'h00, OK);
    // Unlock was high, so this step also gives it a falling edge.
    src(4'h6);
    rd(`ICC_IDX_FLAG, 8'h80, OK);
    src(4'h0);
    rd(`ICC_IDX_FLAG, 8'he0, OK);
    wr(`ICC_IDX_CTRL, 8'h00, OK);
    wr(`ICC_IDX_FLAG, 8'h00, OK);
    rd(`ICC_IDX_FLAG, 8'he0, OK);
    pin(1'b0, 1'b0);
    wr(`ICC_IDX_CTRL, 8'h01, OK);
    wr(`ICC_IDX_ROUTE, 8'h03, OK);
    wr(`ICC_IDX_STATUS_PIN_DRIVER_CONTROL, 8'h33, OK);
    rd(`ICC_IDX_STATUS_PIN_DRIVER_CONTROL, 8'h33, OK);
    pin(1'b1, 1'b1);
    chk({indicator_pin_b_oe_n_o, indicator_pin_a_oe_n_o}, 2'h3);
    chk({pin_b_transient_limit_o, pin_a_transient_limit_o}, 2'h3);
    wr(`ICC_IDX_FLAG, 8'h00, OK);
    pin(1'b0, 1'b0);
    wr(`ICC_IDX_POL, 8'he2, OK);
    src(4'hc);
    rd(`ICC_IDX_FLAG, 8'h40, OK);
    wr(`ICC_IDX_IRQ_MASK, 8'he2, OK);
    pin(1'b1, 1'b1);
    chk(irq_o, 1'b1);
    wr(`ICC_IDX_IRQ_MASK, 8'h00, OK);
    pin(1'b1, 1'b1);
    chk(irq_o, 1'b0);
    wr(`ICC_IDX_IRQ_MASK, 8'he2, OK);
    wr(`ICC_IDX_IRQ_STAT, 8'hff, OK);
    pin(1'b1, 1'b1);
    chk(irq_o, 1'b0);
    rd(`ICC_IDX_IRQ_STAT, 8'h00, OK);
    // A write without the low byte lane is answered but changes nothing.
    s_axi_wstrb_i <= 4'he;
    wr(`ICC_IDX_ROUTE, 8'h00, OK);
    s_axi_wstrb_i <= 4'hf;
    rd(`ICC_IDX_ROUTE, 8'h03, OK);
    stop_test();
  end
endmodule // tb_interrupt_combine_control
